// file: common/wdtw_regs.svh
// register map, field positions, reset values and timing of the watchdog
// assumes a 32-bit AXI4-Lite slave, one aligned word per register
`ifndef WDTW_REGS_SVH
`define WDTW_REGS_SVH

`define WDTW_OFF_CFG      8'h00
`define WDTW_OFF_RCTL     8'h04
`define WDTW_OFF_STAT     8'h08

`define WDTW_CFG_RST      8'h5F
`define WDTW_CFG_W        8

`define WDTW_RC_SOFT_EN   5
`define WDTW_RC_TMO       4
`define WDTW_RC_SLEEP     3
`define WDTW_RC_IDLE      2
`define WDTW_RC_MASK      8'h3C

`define WDTW_CLK_HZ       250000000
`define WDTW_LOW_POWER_RC_OSC_HZ      32000
`define WDTW_PRE_LO       23'h000020
`define WDTW_PRE_HI       23'h000080
`define WDTW_CNT_W        23

`define WDTW_RESP_OKAY    2'h0
`define WDTW_RESP_SLVERR  2'h2

`endif

// file: common/wdtw_pkg.sv
// types shared by the watchdog block
// assumes wdtw_regs.svh for numeric constants
package wdtw_pkg;

  // configuration word layout, bit 7 down to bit 0
  typedef struct packed {
    logic       always_on_select;
    logic       window_disable;
    logic       spare;
    logic       prescale_select;
    logic [3:0] postscale_select;
  } wdtw_cfg_s;

  typedef enum logic [1:0] {
    WDTW_RUN,
    WDTW_SLEEP,
    WDTW_IDLE
  } wdtw_mode_e;

endpackage

// file: hw/wdtw_top.sv
// windowed watchdog timer with AXI4-Lite registers
// assumes core instruction strobes on aclk; aresetn is the device reset
`include "wdtw_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module wdtw_top
  import wdtw_pkg::*;
#(
  parameter int LOW_POWER_RC_OSC_DIV = `WDTW_CLK_HZ / `WDTW_LOW_POWER_RC_OSC_HZ
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        power_save_instr,
  input  wire logic        power_save_idle,
  input  wire logic        wake_request,
  input  wire logic        clock_switch_done,
  output logic             wdt_reset_pulse,
  output logic             wdt_wake_pulse,
  output logic             power_save_active
);

  generate
    if (LOW_POWER_RC_OSC_DIV < 2)
    begin : g_chk
      $error("LOW_POWER_RC_OSC_DIV must be at least 2");
    end
  endgenerate

  localparam int DIV_W = $clog2(LOW_POWER_RC_OSC_DIV);

  wdtw_cfg_s               cfg_reg;
  logic                    soft_enable_reg;
  logic                    timeout_flag_reg;
  logic                    sleep_flag_reg;
  logic                    idle_flag_reg;
  wdtw_mode_e              mode_reg;
  logic [DIV_W-1:0]        osc_div_reg;
  logic [`WDTW_CNT_W-1:0]  wdt_cnt_reg;
  logic [`WDTW_CNT_W-1:0]  period;
  logic                    wdt_on;
  logic                    osc_tick;
  logic                    expire;
  logic                    early_clear;
  logic                    clr_ok;
  logic                    ps_enter;
  logic                    ps_exit;
  logic                    wdt_fault;
  logic                    cnt_clear;
  logic                    wr_go;
  logic                    rd_go;
  logic [7:0]              wr_byte;

  // time-out length in oscillator ticks
  function automatic logic [`WDTW_CNT_W-1:0] wdtw_period(
    input wdtw_cfg_s c
  );
    logic [`WDTW_CNT_W-1:0] base;
    base = c.prescale_select ? `WDTW_PRE_HI : `WDTW_PRE_LO;
    return base << c.postscale_select;
  endfunction

  function automatic logic wdtw_hit(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    return addr[7:2] == off[7:2];
  endfunction

  assign wdt_on = cfg_reg.always_on_select | soft_enable_reg;
  assign period = wdtw_period(cfg_reg);
  assign osc_tick = wdt_on && (osc_div_reg == DIV_W'(LOW_POWER_RC_OSC_DIV - 1));
  assign expire = osc_tick && (wdt_cnt_reg == period - 1'b1);
  assign early_clear = !cfg_reg.window_disable &&
                       (wdt_cnt_reg < period - (period >> 2));
  assign clr_ok = watchdog_clear_instr && mode_reg == WDTW_RUN && wdt_on;
  assign ps_enter = power_save_instr && mode_reg == WDTW_RUN;
  assign ps_exit = mode_reg != WDTW_RUN && (wake_request || expire);
  assign wdt_fault = mode_reg == WDTW_RUN &&
                     (expire || (clr_ok && early_clear));
  assign cnt_clear = clock_switch_done || ps_enter || ps_exit ||
                     clr_ok || wdt_fault || !wdt_on;

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                 !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  assign wr_byte = s_axi_wdata[7:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      osc_div_reg <= '0;
    else if (clk_en)
    begin
      if (cnt_clear || osc_tick)
        osc_div_reg <= '0;
      else
        osc_div_reg <= osc_div_reg + 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wdt_cnt_reg <= '0;
    else if (clk_en)
    begin
      if (cnt_clear || expire)
        wdt_cnt_reg <= '0;
      else if (osc_tick)
        wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
    end
  end

  // power-save mode tracking
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_reg <= WDTW_RUN;
    else if (clk_en)
    begin
      case (mode_reg)
        WDTW_RUN:
          if (ps_enter)
            mode_reg <= power_save_idle ? WDTW_IDLE : WDTW_SLEEP;
        WDTW_SLEEP,
        WDTW_IDLE:
          if (ps_exit)
            mode_reg <= WDTW_RUN;
        default:
          mode_reg <= WDTW_RUN;
      endcase
    end
  end

  // configuration word, software writable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_reg <= wdtw_cfg_s'(`WDTW_CFG_RST);
    else if (clk_en && wr_go && s_axi_wstrb[0] &&
             wdtw_hit(s_axi_awaddr, `WDTW_OFF_CFG))
      cfg_reg <= wdtw_cfg_s'(wr_byte);
  end

  // soft enable cleared on any reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      soft_enable_reg <= 1'b0;
    else if (clk_en)
    begin
      if (wdt_fault)
        soft_enable_reg <= 1'b0;
      else if (wr_go && s_axi_wstrb[0] &&
               wdtw_hit(s_axi_awaddr, `WDTW_OFF_RCTL))
        soft_enable_reg <= wr_byte[`WDTW_RC_SOFT_EN];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timeout_flag_reg <= 1'b0;
    else if (clk_en)
    begin
      if (wdt_fault || (expire && mode_reg != WDTW_RUN))
        timeout_flag_reg <= 1'b1;
      else if (wr_go && s_axi_wstrb[0] &&
               wdtw_hit(s_axi_awaddr, `WDTW_OFF_RCTL))
        timeout_flag_reg <= wr_byte[`WDTW_RC_TMO];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_flag_reg <= 1'b0;
      idle_flag_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_go && s_axi_wstrb[0] &&
          wdtw_hit(s_axi_awaddr, `WDTW_OFF_RCTL))
      begin
        sleep_flag_reg <= wr_byte[`WDTW_RC_SLEEP];
        idle_flag_reg  <= wr_byte[`WDTW_RC_IDLE];
      end
      // entry set overrides a same-cycle write
      if (ps_enter && !power_save_idle)
        sleep_flag_reg <= 1'b1;
      if (ps_enter && power_save_idle)
        idle_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wdt_reset_pulse   <= 1'b0;
      wdt_wake_pulse    <= 1'b0;
      power_save_active <= 1'b0;
    end
    else if (clk_en)
    begin
      wdt_reset_pulse   <= wdt_fault;
      wdt_wake_pulse    <= expire && mode_reg != WDTW_RUN;
      power_save_active <= ps_enter ||
                           (mode_reg != WDTW_RUN && !ps_exit);
    end
  end

  // write channel: address and data taken together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WDTW_RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go)
      begin
        // status word is read-only, writes ignored
        s_axi_bresp  <= (wdtw_hit(s_axi_awaddr, `WDTW_OFF_CFG) ||
                         wdtw_hit(s_axi_awaddr, `WDTW_OFF_RCTL) ||
                         wdtw_hit(s_axi_awaddr, `WDTW_OFF_STAT)) ?
                        `WDTW_RESP_OKAY : `WDTW_RESP_SLVERR;
      end
      // response only after both address and data handshakes
      if (s_axi_awready)
        s_axi_bvalid <= 1'b1;
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `WDTW_RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_arready <= rd_go;
      if (rd_go)
      begin
        s_axi_rresp  <= `WDTW_RESP_OKAY;
        if (wdtw_hit(s_axi_araddr, `WDTW_OFF_CFG))
          s_axi_rdata <= {24'h000000, cfg_reg};
        else if (wdtw_hit(s_axi_araddr, `WDTW_OFF_RCTL))
          s_axi_rdata <= {26'h0000000, soft_enable_reg,
                          timeout_flag_reg, sleep_flag_reg,
                          idle_flag_reg, 2'h0};
        else if (wdtw_hit(s_axi_araddr, `WDTW_OFF_STAT))
          s_axi_rdata <= {4'h0, wdt_on, mode_reg, 2'h0, wdt_cnt_reg};
        else
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `WDTW_RESP_SLVERR;
        end
      end
      // data only after the address handshake
      if (s_axi_arready)
        s_axi_rvalid <= 1'b1;
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: sim/wdtw_top_properties.sv
// port assertions and covers for the windowed watchdog
// assumes a bind onto wdtw_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module wdtw_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic power_save_instr,
  input wire logic wake_request,
  input wire logic wdt_reset_pulse,
  input wire logic wdt_wake_pulse,
  input wire logic power_save_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && clk_en
    && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
    else $error("write not answered in two cycles");
  rd_answer_a: assert property (s_axi_arvalid && clk_en && !s_axi_arready
    && !s_axi_rvalid |=> s_axi_arready ##1 s_axi_rvalid)
    else $error("read not answered in two cycles");
  b_after_aw_a: assert property (s_axi_awready |-> !s_axi_bvalid)
    else $error("write response before address handshake");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rst_single_a: assert property (
    wdt_reset_pulse && clk_en |=> !wdt_reset_pulse)
    else $error("reset pulse longer than one cycle");
  wake_exit_a: assert property (
    wdt_wake_pulse |-> $past(power_save_active) && !power_save_active)
    else $error("wake pulse outside power save");
  no_rst_saving_a: assert property (
    wdt_reset_pulse |-> !$past(power_save_active))
    else $error("reset pulse during power save");
  save_enter_a: assert property (
    power_save_instr && !power_save_active && clk_en |=> power_save_active)
    else $error("power save not entered");
  save_leave_a: assert property (
    power_save_active && wake_request && clk_en |=> !power_save_active)
    else $error("power save not left on wake");

  cover property (wdt_reset_pulse);
  cover property (wdt_wake_pulse);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind wdtw_top wdtw_props u_props (.*);
`default_nettype wire

// file: sim/tb_watchdog_timer_with_window.sv
// self-checking bench for the windowed watchdog
// assumes wdtw_top with a short oscillator divider
`include "wdtw_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_watchdog_timer_with_window;
  localparam int DIV = 4;
  logic        aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1;
  logic        power_save_idle = 1'h0;
  logic [3:0]  ins = 4'h0, s_axi_wstrb = 4'hF;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, wdt_reset_pulse, wdt_wake_pulse, power_save_active;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire         watchdog_clear_instr = ins[0];
  wire         power_save_instr = ins[1];
  wire         clock_switch_done = ins[2];
  wire         wake_request = ins[3];
  int          err_count = 0, cmp_count = 0, n;

  wdtw_top #(.LOW_POWER_RC_OSC_DIV(DIV)) DUT (.*);
  always #2 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // each request valid dropped at the edge where its ready is seen high, each response ready once its valid is seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do
    begin
      @(posedge aclk);
      i++;
      if (s_axi_awready === 1'h1)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1)
        s_axi_wvalid <= 1'h0;
      if (s_axi_arready === 1'h1)
        s_axi_arvalid <= 1'h0;
    end
    while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'h1 && i < 50);
    {s_axi_bready, s_axi_rready} <= 2'h0;
    chk(32'(i < 50), 32'h1);
    if (i >= 50)
      end_of_test;
    chk({30'h0, w ? s_axi_bresp : s_axi_rresp}, a > 8'h08 ? 32'h2 : 32'h0);
    if (!w)
      chk(s_axi_rdata, d);
    // idle edge: no ready dropped and raised in one step
    @(posedge aclk);
  endtask

  task automatic pulse(input int b);
    ins[b] <= 1'h1;
    @(posedge aclk);
    ins <= 4'h0;
  endtask

  task automatic evw(input int lim);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (wdt_reset_pulse !== 1'h1 && wdt_wake_pulse !== 1'h1 && n < lim);
  endtask

  // five cycles of slack each side of the divider phase
  task automatic tmo(input int e);
    evw(e + 6);
    chk(32'(n > e - 6 && n < e + 6), 32'h1);
    if (n >= e + 6)
      end_of_test;
  endtask

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    bus(0, `WDTW_OFF_CFG, 32'h5F);
    bus(0, `WDTW_OFF_RCTL, 32'h0);
    bus(0, 8'h0C, 32'h0);
    bus(1, 8'h0C, 32'hFF);
    bus(1, `WDTW_OFF_STAT, 32'hFF);
    for (int k = 0; k < 4; k++)
    begin
      bus(1, `WDTW_OFF_CFG, 32'h40 | (k[1] << 4) | k[0]);
      bus(1, `WDTW_OFF_RCTL, 32'h20);
      pulse(0);
      tmo(((k[1] ? 128 : 32) << k[0]) * DIV);
      chk({29'h0, power_save_active, wdt_wake_pulse, wdt_reset_pulse}, 32'h1);
      bus(0, `WDTW_OFF_RCTL, 32'h10);
    end
    bus(1, `WDTW_OFF_CFG, 32'h40);
    pulse(0);
    evw(300);
    chk(32'(n), 32'd300);
    bus(1, `WDTW_OFF_CFG, 32'hC0);
    bus(1, `WDTW_OFF_RCTL, 32'h00);
    pulse(0);
    tmo(128);
    bus(0, `WDTW_OFF_RCTL, 32'h10);
    bus(1, `WDTW_OFF_CFG, 32'h00);
    bus(1, `WDTW_OFF_RCTL, 32'h20);
    pulse(0);
    tmo(1);
    bus(0, `WDTW_OFF_RCTL, 32'h10);
    bus(1, `WDTW_OFF_RCTL, 32'h20);
    // clear at count 23, one tick before the last quarter
    repeat (90) @(posedge aclk);
    pulse(0);
    tmo(1);
    bus(0, `WDTW_OFF_RCTL, 32'h10);
    bus(1, `WDTW_OFF_RCTL, 32'h20);
    // clear at count 24, first tick of the last quarter
    repeat (94) @(posedge aclk);
    pulse(0);
    tmo(128);
    bus(1, `WDTW_OFF_CFG, 32'h40);
    bus(1, `WDTW_OFF_RCTL, 32'h20);
    repeat (100) @(posedge aclk);
    pulse(2);
    // frozen cycles must not advance the count
    clk_en <= 1'h0;
    repeat (40) @(posedge aclk);
    clk_en <= 1'h1;
    tmo(128);
    bus(1, `WDTW_OFF_RCTL, 32'h20);
    pulse(1);
    tmo(128);
    chk({29'h0, power_save_active, wdt_wake_pulse, wdt_reset_pulse}, 32'h2);
    bus(0, `WDTW_OFF_RCTL, 32'h38);
    bus(1, `WDTW_OFF_RCTL, 32'h20);
    power_save_idle <= 1'h1;
    pulse(1);
    repeat (20) @(posedge aclk);
    pulse(3);
    tmo(128);
    chk({29'h0, power_save_active, wdt_wake_pulse, wdt_reset_pulse}, 32'h1);
    bus(0, `WDTW_OFF_RCTL, 32'h14);
    end_of_test;
  end
endmodule
`default_nettype wire
